// >>> common/nec_pkg.sv
// Notes on behaviour
// - With row erase enabled and flash selected, the next start erases the flash row under the table pointer.
// - A row erase ignores the six low table pointer bits and covers the whole row.
// - Hardware clears the row erase enable when the row erase finishes.
// - With row erase disabled, a start performs only a write cycle.
// - Setting the start bit together with the write enable launches an EEPROM or program memory cycle as selected.
// - The cycle is self-timed and hardware clears the start bit on completion.
`default_nettype none

package nec_pkg;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned CYCLE_TIME_US = 2000;
	// Least time rounds up to whole clock cycles.
	localparam int unsigned CYCLE_CYCLES  = (CYCLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================================
	// Register map
	// ==========================================================================
	localparam int unsigned ADDR_W     = 3;
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned TP_W       = 22;
	localparam int unsigned ROW_LSB_W  = 6;
	localparam logic [2:0]  OFS_CTRL   = 3'h0;
	localparam logic [2:0]  OFS_TP_LO  = 3'h1;
	localparam logic [2:0]  OFS_TP_HI  = 3'h2;
	localparam logic [2:0]  OFS_TP_UP  = 3'h3;
	localparam logic [2:0]  OFS_INT_ST = 3'h4;
	localparam logic [2:0]  OFS_INT_MK = 3'h5;

	// ==========================================================================
	// Control register fields
	// ==========================================================================
	localparam int unsigned CTRL_SEL_BIT   = 7;
	localparam int unsigned CTRL_CFG_BIT   = 6;
	localparam int unsigned CTRL_FREE_BIT  = 4;
	localparam int unsigned CTRL_ERR_BIT   = 3;
	localparam int unsigned CTRL_PGEN_BIT  = 2;
	localparam int unsigned CTRL_START_BIT = 1;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;

	// ==========================================================================
	// Interrupt status and mask fields
	// ==========================================================================
	localparam int unsigned INT_DONE_BIT = 0;
	localparam int unsigned INT_ERR_BIT  = 1;
	localparam logic [1:0]  INT_RESET    = 2'h0;

	// ==========================================================================
	// Sequencer states
	// ==========================================================================
	typedef enum logic [2:0]
	{
		NEC_IDLE  = 3'b001,
		NEC_ERASE = 3'b010,
		NEC_WRITE = 3'b100
	} nec_state_t;

endpackage : nec_pkg

`default_nettype wire

// >>> verilog/nec_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none

module nec_cycle_timer
#(
	parameter int unsigned CYCLES = nec_pkg::CYCLE_CYCLES,
	parameter int unsigned CNT_W  = $clog2(CYCLES + 1)
)
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic start_in,
	input  wire logic abort_in,
	output var  logic done_out,
	output var  logic busy_out
);

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed
	{
		logic             busy;
		logic             done;
		logic [CNT_W-1:0] cnt;
	} nec_tmr_state_t;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

	nec_tmr_state_t s_q;
	nec_tmr_state_t s_d;

	// Counts the self-timed cycle; an abort wins over a start.
	always_comb
	begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (abort_in)
		begin
			s_d.busy = 1'b0;
			s_d.cnt  = '0;
		end
		else if (start_in)
		begin
			s_d.busy = 1'b1;
			s_d.cnt  = '0;
		end
		else if (s_q.busy)
		begin
			if (s_q.cnt == LAST)
			begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.cnt  = '0;
			end
			else
			begin
				s_d.cnt = CNT_W'(s_q.cnt + 1'b1);
			end
		end
	end

	// Registers the timer state.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign done_out = s_q.done;
	assign busy_out = s_q.busy;

endmodule : nec_cycle_timer

`default_nettype wire

// >>> verilog/nec_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module nec_ctrl
#(
	parameter int unsigned CYCLE_CYCLES = nec_pkg::CYCLE_CYCLES
)
(
	input  wire logic                        clock_in,
	input  wire logic                        arst_n_in,
	input  wire logic                        reset_req_in,
	input  wire logic [nec_pkg::ADDR_W-1:0]  addr_in,
	input  wire logic [nec_pkg::DATA_W-1:0]  wdata_in,
	input  wire logic                        wr_in,
	input  wire logic                        rd_in,
	output var  logic [nec_pkg::DATA_W-1:0]  rdata_out,
	output var  logic                        irq_out,
	output var  logic                        erase_active_out,
	output var  logic                        write_active_out,
	output var  logic                        flash_or_eeprom_select_out,
	output var  logic                        config_space_select_out,
	output var  logic [nec_pkg::TP_W-1:0]    nvm_addr_out
);

	// ==========================================================================
	// Reset release
	// ==========================================================================
	logic [1:0] rst_sync_q;
	logic       rst_n;

	// Releases the asynchronous reset through two flip-flops.
	always_ff @(posedge clock_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_n = rst_sync_q[1];

	// ==========================================================================
	// State
	// ==========================================================================
	typedef struct packed
	{
		nec_pkg::nec_state_t          st;
		logic                         sel;
		logic                         cfg;
		logic                         free;
		logic                         err;
		logic                         pgen;
		logic                         start;
		logic [nec_pkg::TP_W-1:0]     tp;
		logic [nec_pkg::TP_W-1:0]     addr;
		logic                         erase_act;
		logic                         write_act;
		logic                         flash_sel;
		logic                         cfg_sel;
		logic [1:0]                   int_st;
		logic [1:0]                   int_mk;
		logic [nec_pkg::DATA_W-1:0]   rdata;
		logic                         irq;
	} nec_ctrl_state_t;

	localparam nec_ctrl_state_t CTRL_RST = '{st: nec_pkg::NEC_IDLE, default: '0};

	nec_ctrl_state_t s_q;
	nec_ctrl_state_t s_d;
	logic            tmr_done;
	logic            tmr_busy;
	logic            launch;
	logic            busy;
	logic            is_erase;

	// ==========================================================================
	// Register read decode
	// ==========================================================================
	function automatic logic [7:0] nec_read(input nec_ctrl_state_t s, input logic [2:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			nec_pkg::OFS_CTRL:
			begin
				v[nec_pkg::CTRL_SEL_BIT]   = s.sel;
				v[nec_pkg::CTRL_CFG_BIT]   = s.cfg;
				v[nec_pkg::CTRL_FREE_BIT]  = s.free;
				v[nec_pkg::CTRL_ERR_BIT]   = s.err;
				v[nec_pkg::CTRL_PGEN_BIT]  = s.pgen;
				v[nec_pkg::CTRL_START_BIT] = s.start;
			end
			nec_pkg::OFS_TP_LO:  v = s.tp[7:0];
			nec_pkg::OFS_TP_HI:  v = s.tp[15:8];
			nec_pkg::OFS_TP_UP:  v = {2'h0, s.tp[21:16]};
			nec_pkg::OFS_INT_ST: v = {6'h00, s.int_st};
			nec_pkg::OFS_INT_MK: v = {6'h00, s.int_mk};
			default:             v = 8'h00;
		endcase
		return v;
	endfunction : nec_read

	// ==========================================================================
	// Cycle timer
	// ==========================================================================
	nec_cycle_timer
	#(
		.CYCLES   (CYCLE_CYCLES)
	)
	u_timer
	(
		.clk_in   (clock_in),
		.rst_n_in (rst_n),
		.start_in (launch),
		.abort_in (reset_req_in),
		.done_out (tmr_done),
		.busy_out (tmr_busy)
	);

	// A start needs the enable in the same write, an idle sequencer and no reset.
	assign busy     = (s_q.st != nec_pkg::NEC_IDLE);
	assign launch   = wr_in && (addr_in == nec_pkg::OFS_CTRL) && wdata_in[nec_pkg::CTRL_START_BIT]
		&& wdata_in[nec_pkg::CTRL_PGEN_BIT] && !busy && !reset_req_in;
	assign is_erase = s_q.free && s_q.sel;

	// ==========================================================================
	// Next state
	// ==========================================================================
	// Register writes, cycle launch, completion, reset abort and interrupts.
	always_comb
	begin
		s_d       = s_q;
		s_d.rdata = 8'h00;
		if (rd_in)
		begin
			s_d.rdata = nec_read(s_q, addr_in);
			if (addr_in == nec_pkg::OFS_INT_ST)
				s_d.int_st = 2'h0;
		end
		if (wr_in && !reset_req_in)
		begin
			unique case (addr_in)
				nec_pkg::OFS_CTRL:
				begin
					// Selects and row erase enable hold still while a cycle runs.
					if (!busy)
					begin
						s_d.sel  = wdata_in[nec_pkg::CTRL_SEL_BIT];
						s_d.cfg  = wdata_in[nec_pkg::CTRL_CFG_BIT];
						s_d.free = wdata_in[nec_pkg::CTRL_FREE_BIT];
					end
					s_d.err  = wdata_in[nec_pkg::CTRL_ERR_BIT];
					s_d.pgen = wdata_in[nec_pkg::CTRL_PGEN_BIT];
				end
				nec_pkg::OFS_TP_LO:  s_d.tp[7:0]   = wdata_in;
				nec_pkg::OFS_TP_HI:  s_d.tp[15:8]  = wdata_in;
				nec_pkg::OFS_TP_UP:  s_d.tp[21:16] = wdata_in[5:0];
				nec_pkg::OFS_INT_MK: s_d.int_mk    = wdata_in[1:0];
				default:             s_d.int_mk    = s_q.int_mk;
			endcase
		end
		if (launch)
		begin
			// Erase uses the written selects so one write can set up and start.
			s_d.start     = 1'b1;
			s_d.flash_sel = wdata_in[nec_pkg::CTRL_SEL_BIT];
			s_d.cfg_sel   = wdata_in[nec_pkg::CTRL_CFG_BIT];
			if (wdata_in[nec_pkg::CTRL_FREE_BIT] && wdata_in[nec_pkg::CTRL_SEL_BIT])
			begin
				s_d.st        = nec_pkg::NEC_ERASE;
				s_d.erase_act = 1'b1;
				s_d.addr      = {s_q.tp[21:6], 6'h00};
			end
			else
			begin
				s_d.st        = nec_pkg::NEC_WRITE;
				s_d.write_act = 1'b1;
				s_d.addr      = s_q.tp;
			end
		end
		if (busy && tmr_done && !reset_req_in)
		begin
			s_d.st        = nec_pkg::NEC_IDLE;
			s_d.start     = 1'b0;
			s_d.erase_act = 1'b0;
			s_d.write_act = 1'b0;
			s_d.err       = 1'b0;
			s_d.int_st[nec_pkg::INT_DONE_BIT] = 1'b1;
			if (s_q.st == nec_pkg::NEC_ERASE)
				s_d.free = 1'b0;
		end
		if (reset_req_in)
		begin
			// A device reset aborts the cycle but keeps both memory selects.
			if (busy)
			begin
				s_d.err = 1'b1;
				s_d.int_st[nec_pkg::INT_ERR_BIT] = 1'b1;
			end
			s_d.st        = nec_pkg::NEC_IDLE;
			s_d.start     = 1'b0;
			s_d.pgen      = 1'b0;
			s_d.free      = 1'b0;
			s_d.erase_act = 1'b0;
			s_d.write_act = 1'b0;
		end
		s_d.irq = |(s_d.int_st & s_d.int_mk);
	end

	// Registers the whole control state.
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= CTRL_RST;
		else
			s_q <= s_d;
	end

	// Outputs come straight from the state flip-flops.
	assign rdata_out                  = s_q.rdata;
	assign irq_out                    = s_q.irq;
	assign erase_active_out           = s_q.erase_act;
	assign write_active_out           = s_q.write_act;
	assign flash_or_eeprom_select_out = s_q.flash_sel;
	assign config_space_select_out    = s_q.cfg_sel;
	assign nvm_addr_out               = s_q.addr;

	// ==========================================================================
	// Assertions
	// ==========================================================================
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n);

	// Counts cycles since launch so the self-timed length can be checked.
	logic [31:0] run_cnt_q;

	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
			run_cnt_q <= 32'h0000_0000;
		else if (launch)
			run_cnt_q <= 32'h0000_0000;
		else if (s_q.start)
			run_cnt_q <= run_cnt_q + 32'h0000_0001;
	end

	property p_row_erase;
		launch && wdata_in[nec_pkg::CTRL_FREE_BIT] && wdata_in[nec_pkg::CTRL_SEL_BIT]
			|=> erase_active_out && !write_active_out && (s_q.st == nec_pkg::NEC_ERASE);
	endproperty
	a_row_erase: assert property (p_row_erase) else $error("Row erase not started.");

	property p_row_align;
		$rose(erase_active_out) |-> (nvm_addr_out[5:0] == 6'h00)
			&& (nvm_addr_out[21:6] == $past(s_q.tp[21:6]));
	endproperty
	a_row_align: assert property (p_row_align) else $error("Row erase address not aligned.");

	property p_free_clear;
		(s_q.st == nec_pkg::NEC_ERASE) && tmr_done |=> !s_q.free && !s_q.start;
	endproperty
	a_free_clear: assert property (p_free_clear) else $error("Row erase enable not cleared.");

	property p_write_only;
		launch && !wdata_in[nec_pkg::CTRL_FREE_BIT] |=> write_active_out && !erase_active_out;
	endproperty
	a_write_only: assert property (p_write_only) else $error("Erase without row erase enable.");

	property p_start_sets;
		launch |=> s_q.start && (erase_active_out != write_active_out);
	endproperty
	a_start_sets: assert property (p_start_sets) else $error("Start did not launch a cycle.");

	property p_self_timed;
		$fell(s_q.start) |-> $past(reset_req_in) || ($past(tmr_done) && (run_cnt_q == CYCLE_CYCLES + 1));
	endproperty
	a_self_timed: assert property (p_self_timed) else $error("Start bit cleared at wrong time.");

	property p_zero_ignored;
		wr_in && (addr_in == nec_pkg::OFS_CTRL) && !wdata_in[nec_pkg::CTRL_START_BIT] && s_q.start
			&& !tmr_done && !reset_req_in |=> s_q.start;
	endproperty
	a_zero_ignored: assert property (p_zero_ignored) else $error("Software cleared the start bit.");

	property p_abort_err;
		reset_req_in && busy |=> s_q.err && !s_q.start && s_q.int_st[nec_pkg::INT_ERR_BIT]
			&& (irq_out || !s_q.int_mk[nec_pkg::INT_ERR_BIT]);
	endproperty
	a_abort_err: assert property (p_abort_err) else $error("Aborted cycle did not flag error.");

	property p_done_ok;
		busy && tmr_done && !reset_req_in |=> !s_q.err;
	endproperty
	a_done_ok: assert property (p_done_ok) else $error("Error flag left set after completion.");

	// The timer may only run while the sequencer holds a cycle open.
	property p_timer_sync;
		tmr_busy |-> busy;
	endproperty
	a_timer_sync: assert property (p_timer_sync) else $error("Timer ran without a cycle.");

	c_erase_done: cover property ((s_q.st == nec_pkg::NEC_ERASE) && tmr_done);
	c_write_done: cover property ((s_q.st == nec_pkg::NEC_WRITE) && tmr_done);
	c_abort:      cover property (reset_req_in && busy);
	c_irq:        cover property ($rose(irq_out));

endmodule : nec_ctrl

`default_nettype wire

// >>> dv/nec_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// =============================================
// Core side of the register bus: one-cycle strobes, launched just after a rising edge.
// =============================================
module nec_core_model
(
	input  wire logic                       clock_in,
	input  wire logic [nec_pkg::DATA_W-1:0] rdata_in,
	output var  logic [nec_pkg::ADDR_W-1:0] addr_out,
	output var  logic [nec_pkg::DATA_W-1:0] wdata_out,
	output var  logic                       wr_out,
	output var  logic                       rd_out
);
	// Idle bus at time zero.
	initial
	begin
		addr_out = 3'h0;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// Software writes whatever value it likes; a zero in the start bit is left to the block to ignore.
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clock_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask : wr_reg

	// Read data are taken in the one cycle after the strobe, once settled.
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clock_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1;
		d = rdata_in;
	endtask : rd_reg
endmodule : nec_core_model

`default_nettype wire

// >>> dv/nvm_erase_write_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module nvm_erase_write_control_tb;
	localparam int unsigned N = 12;
	logic        clock_in;
	logic        arst_n_in;
	logic        reset_req;
	logic [2:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        wr;
	logic        rd;
	logic        irq;
	logic        erase_act;
	logic        write_act;
	logic        sel;
	logic        cfg;
	logic [21:0] nvm_addr;
	int          error_cnt;
	int          check_count;
	logic [7:0]  codes[6] = '{8'h96, 8'h86, 8'h16, 8'h06, 8'hC6, 8'hD6};
	logic [2:0]  idle_regs[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};

	nec_ctrl #(.CYCLE_CYCLES(N)) i_nec_ctrl (.clock_in(clock_in), .arst_n_in(arst_n_in),
		.reset_req_in(reset_req), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .irq_out(irq), .erase_active_out(erase_act), .write_active_out(write_act),
		.flash_or_eeprom_select_out(sel), .config_space_select_out(cfg), .nvm_addr_out(nvm_addr));

	nec_core_model i_nec_core_model (.clock_in(clock_in), .rdata_in(rdata), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));

	// =============================================
	// Clock, checks and verdict
	// =============================================
	// Free-running 10 MHz core clock.
	initial
	begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [21:0] got, input logic [21:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk

	// Reads a register and compares it.
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] v;
		i_nec_core_model.rd_reg(a, v);
		chk(v, exp);
	endtask : rd_chk

	// Prints the verdict and ends the run.
	task automatic give_verdict;
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	// A start erases only when flash is selected and row erase is enabled.
	function automatic logic is_erase(input logic [7:0] c);
		return c[7] & c[4];
	endfunction : is_erase

	// Erase targets the whole row, so the six low pointer bits drop out.
	function automatic logic [21:0] exp_addr(input logic [7:0] c, input logic [21:0] tp);
		return is_erase(c) ? {tp[21:6], 6'h00} : tp;
	endfunction : exp_addr

	// Launches one cycle, pokes a zero start bit mid-cycle, then completes or aborts it.
	task automatic run_cycle(input logic [7:0] c, input logic [1:0] m, input bit abort);
		logic [21:0] tp;
		tp = 22'($urandom);
		i_nec_core_model.wr_reg(3'h5, {6'h00, m});
		i_nec_core_model.wr_reg(3'h1, tp[7:0]);
		i_nec_core_model.wr_reg(3'h2, tp[15:8]);
		i_nec_core_model.wr_reg(3'h3, {2'b11, tp[21:16]});
		rd_chk(3'h3, {2'b00, tp[21:16]});
		i_nec_core_model.wr_reg(3'h0, c);
		#1;
		chk(erase_act, is_erase(c));
		chk(write_act, !is_erase(c));
		chk(nvm_addr, exp_addr(c, tp));
		chk({sel, cfg}, c[7:6]);
		i_nec_core_model.wr_reg(3'h0, 8'h04);
		rd_chk(3'h0, c & 8'hD6);
		if (abort)
		begin
			@(posedge clock_in);
			reset_req <= 1'b1;
			@(posedge clock_in);
			reset_req <= 1'b0;
			#1;
			chk({erase_act, write_act}, 2'b00);
			rd_chk(3'h0, {c[7:6], 6'h08});
			chk(irq, m[1]);
			rd_chk(3'h4, 8'h02);
		end
		else
		begin
			repeat (N - 4) @(posedge clock_in);
			#1;
			chk({erase_act, write_act}, {is_erase(c), !is_erase(c)});
			@(posedge clock_in);
			#1;
			chk({erase_act, write_act}, 2'b00);
			rd_chk(3'h0, {c[7:6], 1'b0, c[4] & ~c[7], 4'h4});
			chk(irq, m[0]);
			rd_chk(3'h4, 8'h01);
		end
		repeat (2) @(posedge clock_in);
		#1;
		chk(irq, 1'b0);
	endtask : run_cycle

	// =============================================
	// Main sequence
	// =============================================
	// Resets, checks idle values, then runs listed and random cycles.
	initial
	begin
		error_cnt = 0;
		check_count = 0;
		reset_req = 1'b0;
		arst_n_in = 1'b0;
		void'($urandom(88));
		repeat (4) @(posedge clock_in);
		arst_n_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		foreach (idle_regs[i])
			rd_chk(idle_regs[i], 8'h00);
		i_nec_core_model.wr_reg(3'h0, 8'h82);
		#1;
		chk(write_act, 1'b0);
		foreach (codes[i])
			run_cycle(codes[i], 2'(i), i == 3);
		for (int k = 0; k < 6; k++)
			run_cycle(8'($urandom) & 8'hD0 | 8'h06, 2'($urandom), k[0]);
		give_verdict();
	end

	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		#2000000;
		error_cnt++;
		give_verdict();
	end
endmodule : nvm_erase_write_control_tb

`default_nettype wire
